// ---- ioer_handler.sv ----
// Processing element side of the channel controller response lines
// What this block does
// - Condition code from controller at operation end is loaded into the status-word field.
// - General response line ends the pending handshake for an I/O instruction, an I/O interrupt or a machine-check logout.
// - Each timeout-reset assertion from the busy controller reloads the response countdown to its maximum while a response is awaited.
// - Protected storage area lockout causes a program interruption.
// - Controller direct-interrupt line causes an external interrupt.
// - Element check, as pulse or level, causes an external interrupt.
// - Battery status line, static or pulsed, causes an external interrupt.
// - Over-temperature check causes an external interrupt.
// - Machine-check request from the busy controller abandons the current I/O process.
// - Instruction fetch with machine-check pending grants permit, then times the logout.
// - Controller holds timeout-reset during logout; wait ends on response or countdown expiry.
// - Either outcome completes the machine-check interrupt with no local logout.
// - Machine-check old status word names the controller in bits 30 and 31.
// - Simultaneous machine-check requests are served controller 3, then 2, then 1.
// - I/O instruction strobe stays asserted and steady until the controller responds or requests a machine check, or the response countdown expires.
// - Permit I/O interrupt is asserted only in answer to that controller's request.
`timescale 1ns/100ps

module ioer_handler #(
	parameter int NUM_CTL     = ioer_pkg::MAX_CTL,
	parameter int TIMEOUT_CYC = ioer_pkg::RESP_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic                                  clk_sys,
	input  wire logic                                  rst,
	// Lines from the channel controllers
	input  wire ioer_pkg::ioer_link_type [NUM_CTL-1:0] ctlIn,
	// Processing element requests
	input  wire logic                                  ioCmdValid,
	input  wire logic [1:0]                            ioCmdSel,
	input  wire logic                                  fetchPoint,
	input  wire logic                                  irqEnable,
	// Lines to the channel controllers
	output logic [NUM_CTL-1:0]                         ioStrobe_ff,
	output logic [NUM_CTL-1:0]                         permitIoIrq_ff,
	output logic [NUM_CTL-1:0]                         permitMc_ff,
	// Status toward the processing element
	output logic                                       busy_ff,
	output logic [1:0]                                 condCode_ff,
	output logic                                       ccValid_ff,
	output logic                                       checkErr_ff,
	output logic                                       ioAbort_ff,
	output logic                                       timeoutErr_ff,
	output logic                                       ioIrqDone_ff,
	output logic                                       mcIntDone_ff,
	output logic [1:0]                                 mcCode_ff,
	output logic                                       mcTimedOut_ff,
	output logic                                       programIrq_ff,
	output logic                                       extIrq_ff,
	output ioer_pkg::ioer_ext_type                     extCause_ff,
	output logic                                       cfgAck_ff,
	output logic                                       backspaceDone_ff,
	output logic                                       ticSeen_ff,
	output logic                                       gapSeen_ff
);
	import ioer_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] CNT_MAX  = TW'(TIMEOUT_CYC);
	localparam logic [TW-1:0] CNT_ZERO = '0;
	localparam logic [TW-1:0] CNT_ONE  = TW'(1);

	// Controller numbers travel in two bits, so no more controllers than the code can name
	if (NUM_CTL < 1 || NUM_CTL > MAX_CTL) begin : gBadCtl
		$error("NUM_CTL must lie between 1 and 3");
	end
	if (TIMEOUT_CYC < 1) begin : gBadTimeout
		$error("TIMEOUT_CYC must be at least one");
	end

	// Edge detection per controller; the lines are synchronous to clk_sys
	ioer_link_type [NUM_CTL-1:0] prev_ff;
	ioer_link_type [NUM_CTL-1:0] rise;
	logic          [NUM_CTL-1:0] mcPend;
	logic          [NUM_CTL-1:0] irqPend;

	genvar g;
	generate
		for (g = 0; g < NUM_CTL; g++) begin : gCtl
			assign rise[g]    = ctlIn[g] & ~prev_ff[g];
			assign mcPend[g]  = ctlIn[g].mcReq;
			assign irqPend[g] = ctlIn[g].ioIrqReq;
		end
	endgenerate

	// Handshake state
	ioer_state_type state_ff, nxt_state;
	logic [1:0]     sel_ff, nxt_sel;
	logic [TW-1:0]  cnt_ff, nxt_cnt;
	logic [1:0]     nxt_condCode;
	logic [1:0]     nxt_mcCode;
	logic           nxt_ccValid, nxt_checkErr, nxt_ioAbort, nxt_timeoutErr;
	logic           nxt_ioIrqDone, nxt_mcIntDone, nxt_mcTimedOut;
	logic [1:0]     mcPick, irqPick;
	logic           ctlResp, ctlCheck, ctlMc, ctlHold, expired;

	always_comb begin
		mcPick  = 2'h0;
		irqPick = 2'h0;
		// Later, higher-numbered controllers override: 3 before 2 before 1
		for (int i = 0; i < NUM_CTL; i++) begin
			if (mcPend[i])
				mcPick = 2'(i);
			if (irqPend[i])
				irqPick = 2'(i);
		end
	end

	always_comb begin
		ctlResp  = rise[sel_ff].response;
		ctlCheck = rise[sel_ff].checkResp;
		ctlMc    = ctlIn[sel_ff].mcReq;
		ctlHold  = ctlIn[sel_ff].timeoutReset;
		expired  = (cnt_ff == CNT_ZERO);
		nxt_state      = state_ff;
		nxt_sel        = sel_ff;
		nxt_cnt        = cnt_ff;
		nxt_condCode   = condCode_ff;
		nxt_mcCode     = mcCode_ff;
		nxt_mcTimedOut = mcTimedOut_ff;
		nxt_ccValid    = 1'b0;
		nxt_checkErr   = 1'b0;
		nxt_ioAbort    = 1'b0;
		nxt_timeoutErr = 1'b0;
		nxt_ioIrqDone  = 1'b0;
		nxt_mcIntDone  = 1'b0;
		if (state_ff != ST_IDLE && state_ff != ST_MCS)
			nxt_cnt = ctlHold ? CNT_MAX : (expired ? cnt_ff : cnt_ff - CNT_ONE);
		case (state_ff)
			ST_IDLE: begin
				nxt_cnt = CNT_MAX;
				if (fetchPoint && (|mcPend)) begin
					nxt_sel   = mcPick;
					nxt_state = ST_MCW;
				end else if (ioCmdValid && 32'(ioCmdSel) < NUM_CTL) begin
					nxt_sel   = ioCmdSel;
					nxt_state = ST_IO;
				end else if (irqEnable && (|irqPend)) begin
					nxt_sel   = irqPick;
					nxt_state = ST_IRQ;
				end
			end
			ST_IO, ST_IRQ: begin
				if (ctlMc) begin
					nxt_ioAbort = 1'b1;
					nxt_state   = ST_IDLE;
				end else if (ctlCheck) begin
					nxt_checkErr = 1'b1;
					nxt_state    = ST_IDLE;
				end else if (ctlResp) begin
					if (state_ff == ST_IO) begin
						nxt_condCode = ctlIn[sel_ff].condCode;
						nxt_ccValid  = 1'b1;
					end else begin
						nxt_ioIrqDone = 1'b1;
					end
					nxt_state = ST_IDLE;
				end else if (expired && !ctlHold) begin
					nxt_timeoutErr = 1'b1;
					nxt_state      = ST_IDLE;
				end
			end
			ST_MCW: begin
				if (ctlResp || (expired && !ctlHold)) begin
					nxt_mcTimedOut = !ctlResp;
					nxt_mcCode     = sel_ff + MC_ID_BASE;
					nxt_state      = ST_MCS;
				end
			end
			ST_MCS: begin
				// Old and new status words are swapped here; no local logout
				nxt_mcIntDone = 1'b1;
				nxt_state     = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Outputs follow the next state so each comes straight from a flip-flop
	logic [NUM_CTL-1:0] nxt_ioStrobe, nxt_permitIoIrq, nxt_permitMc;
	always_comb begin
		nxt_ioStrobe    = '0;
		nxt_permitIoIrq = '0;
		nxt_permitMc    = '0;
		for (int i = 0; i < NUM_CTL; i++) begin
			nxt_ioStrobe[i]    = (nxt_state == ST_IO)  && (nxt_sel == 2'(i));
			nxt_permitIoIrq[i] = (nxt_state == ST_IRQ) && (nxt_sel == 2'(i));
			nxt_permitMc[i]    = (nxt_state == ST_MCW) && (nxt_sel == 2'(i));
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff       <= ST_IDLE;
			sel_ff         <= 2'h0;
			cnt_ff         <= CNT_ZERO;
			condCode_ff    <= 2'h0;
			mcCode_ff      <= 2'h0;
			mcTimedOut_ff  <= 1'b0;
			ccValid_ff     <= 1'b0;
			checkErr_ff    <= 1'b0;
			ioAbort_ff     <= 1'b0;
			timeoutErr_ff  <= 1'b0;
			ioIrqDone_ff   <= 1'b0;
			mcIntDone_ff   <= 1'b0;
			ioStrobe_ff    <= '0;
			permitIoIrq_ff <= '0;
			permitMc_ff    <= '0;
			busy_ff        <= 1'b0;
		end else begin
			state_ff       <= nxt_state;
			sel_ff         <= nxt_sel;
			cnt_ff         <= nxt_cnt;
			condCode_ff    <= nxt_condCode;
			mcCode_ff      <= nxt_mcCode;
			mcTimedOut_ff  <= nxt_mcTimedOut;
			ccValid_ff     <= nxt_ccValid;
			checkErr_ff    <= nxt_checkErr;
			ioAbort_ff     <= nxt_ioAbort;
			timeoutErr_ff  <= nxt_timeoutErr;
			ioIrqDone_ff   <= nxt_ioIrqDone;
			mcIntDone_ff   <= nxt_mcIntDone;
			ioStrobe_ff    <= nxt_ioStrobe;
			permitIoIrq_ff <= nxt_permitIoIrq;
			permitMc_ff    <= nxt_permitMc;
			busy_ff        <= (nxt_state != ST_IDLE);
		end
	end

	// Event lines: a held level raises one interrupt only, at its leading edge
	ioer_ext_type nxt_extCause;
	logic         nxt_extIrq, nxt_programIrq, nxt_cfgAck;
	logic         nxt_backspace, nxt_tic, nxt_gap;
	always_comb begin
		nxt_extCause   = '0;
		nxt_programIrq = 1'b0;
		nxt_cfgAck     = 1'b0;
		nxt_backspace  = 1'b0;
		nxt_tic        = 1'b0;
		nxt_gap        = 1'b0;
		for (int i = 0; i < NUM_CTL; i++) begin
			nxt_extCause.directIrq     |= rise[i].directIrq;
			nxt_extCause.elementCheck  |= rise[i].elementCheck;
			nxt_extCause.batteryStatus |= rise[i].batteryStatus;
			nxt_extCause.overTemp      |= rise[i].overTemp;
			nxt_programIrq             |= rise[i].areaLockout;
			nxt_cfgAck                 |= rise[i].cfgAck;
			nxt_backspace              |= rise[i].backspaceDone;
			nxt_tic                    |= rise[i].transfer_in_channel;
			nxt_gap                    |= rise[i].gap;
		end
		nxt_extIrq = |nxt_extCause;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prev_ff          <= '0;
			extCause_ff      <= '0;
			extIrq_ff        <= 1'b0;
			programIrq_ff    <= 1'b0;
			cfgAck_ff        <= 1'b0;
			backspaceDone_ff <= 1'b0;
			ticSeen_ff       <= 1'b0;
			gapSeen_ff       <= 1'b0;
		end else begin
			prev_ff          <= ctlIn;
			extCause_ff      <= nxt_extCause;
			extIrq_ff        <= nxt_extIrq;
			programIrq_ff    <= nxt_programIrq;
			cfgAck_ff        <= nxt_cfgAck;
			backspaceDone_ff <= nxt_backspace;
			ticSeen_ff       <= nxt_tic;
			gapSeen_ff       <= nxt_gap;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_mcGrant;
		(state_ff == ST_MCW) && (ctlResp || (expired && !ctlHold));
	endsequence
	sequence s_mcFinish;
		##1 (state_ff == ST_MCS) ##1 mcIntDone_ff;
	endsequence

	a_cc_load: assert property ((state_ff == ST_IO) && ctlResp && !ctlMc && !ctlCheck
		|=> ccValid_ff && condCode_ff == $past(ctlIn[sel_ff].condCode))
		else $error("condition code not loaded on response");
	a_resp_end: assert property (((state_ff == ST_IO) || (state_ff == ST_IRQ))
		&& ctlResp |=> !busy_ff)
		else $error("response did not end handshake");
	a_hold_reload: assert property ((state_ff != ST_IDLE) && (state_ff != ST_MCS)
		&& ctlHold |=> cnt_ff == CNT_MAX)
		else $error("timeout reset did not reload countdown");
	a_check_ext: assert property (rise[0].elementCheck || rise[0].batteryStatus
		|=> extIrq_ff && (extCause_ff.elementCheck || extCause_ff.batteryStatus))
		else $error("element check or battery line did not interrupt");
	a_ext_irq: assert property (rise[0].overTemp || rise[0].directIrq
		|=> extIrq_ff && (extCause_ff.overTemp || extCause_ff.directIrq))
		else $error("external interrupt missing");
	a_abort_mc: assert property (((state_ff == ST_IO) || (state_ff == ST_IRQ))
		&& ctlMc |=> ioAbort_ff && state_ff == ST_IDLE)
		else $error("machine check did not abandon I/O");
	a_mc_seq: assert property (s_mcGrant |-> s_mcFinish)
		else $error("machine-check interrupt not completed");
	a_mc_code: assert property (s_mcGrant |=> mcCode_ff == $past(sel_ff) + MC_ID_BASE)
		else $error("controller identity wrong in code");
	a_mc_prio: assert property ((state_ff == ST_IDLE) && fetchPoint && (|mcPend)
		|=> permitMc_ff == (1 << $past(mcPick)))
		else $error("machine-check priority or permit wrong");
	a_strobe_hold: assert property ((state_ff == ST_IO) && !ctlResp
		&& !ctlMc && !ctlCheck && !(expired && !ctlHold)
		|=> $stable(ioStrobe_ff) && |ioStrobe_ff)
		else $error("strobe dropped before response");
	a_permit_req: assert property ($rose(|permitIoIrq_ff)
		|-> |(permitIoIrq_ff & $past(irqPend)))
		else $error("permit without request");
	a_lock_irq: assert property (rise[0].areaLockout |=> programIrq_ff)
		else $error("lockout did not raise program interrupt");
endmodule

// ---- ioer_pkg.sv ----
// Constants and carrier types for the channel controller response handler
package ioer_pkg;
	// Element clock and response countdown
	localparam int CLK_PERIOD_NS   = 40;
	localparam int RESP_TIMEOUT_NS = 100000;
	localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;

	// Controllers and machine-check identity in interrupt-code bits 30 (high) and 31 (low)
	localparam int       MAX_CTL     = 3;
	localparam logic [1:0] MC_ID_BASE = 2'h1;
	localparam int       MC_CODE_HI  = 30;
	localparam int       MC_CODE_LO  = 31;

	// Control state, one-hot
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_IO    = 5'h02,
		ST_IRQ   = 5'h04,
		ST_MCW   = 5'h08,
		ST_MCS   = 5'h10
	} ioer_state_type;

	// One-way lines from one channel controller
	typedef struct packed {
		logic [1:0] condCode;
		logic       response;
		logic       cfgAck;
		logic       checkResp;
		logic       timeoutReset;
		logic       areaLockout;
		logic       backspaceDone;
		logic       directIrq;
		logic       transfer_in_channel;
		logic       gap;
		logic       elementCheck;
		logic       batteryStatus;
		logic       overTemp;
		logic       ioIrqReq;
		logic       mcReq;
	} ioer_link_type;

	// Sources of an external interrupt
	typedef struct packed {
		logic elementCheck;
		logic batteryStatus;
		logic overTemp;
		logic directIrq;
	} ioer_ext_type;
endpackage

// ---- ioer_ctl_model.sv ----
// Behavioural channel controller that answers the handler's requests
`timescale 1ns/100ps

module ioer_ctl_model (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Grants from the handler
	input  wire logic                    strobe,
	input  wire logic                    permitIo,
	input  wire logic                    permitMc,
	// Bench controls
	input  wire ioer_pkg::ioer_link_type evIn,
	input  wire logic [1:0]              cc,
	input  wire logic [7:0]              delay,
	input  wire logic [7:0]              toHold,
	input  wire logic                    badParity,
	input  wire logic                    mute,
	input  wire logic                    maskOn,
	// Lines toward the handler
	output ioer_pkg::ioer_link_type      link
);
	import ioer_pkg::*;

	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic       served_ff;
	logic       nxt_served;
	logic       active;
	logic       answer;

	assign active = strobe | permitIo | permitMc;
	// One answer per grant; a muted controller lets the handler's countdown expire
	// Under an interrupt permit the answer stands for the status and old status-word store
	assign answer = active & ~served_ff & ~mute & (cnt_ff == delay);

	always_comb begin
		nxt_cnt    = active ? cnt_ff + ((cnt_ff != 8'hff) ? 8'h01 : 8'h00) : 8'h00;
		nxt_served = active & (served_ff | answer);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_ff    <= 8'h00;
			served_ff <= 1'b0;
		end else begin
			cnt_ff    <= nxt_cnt;
			served_ff <= nxt_served;
		end
	end

	always_comb begin
		link              = evIn;
		// Code stands through the transfer; outside it the lines show the inverse
		link.condCode     = active ? cc : ~cc;
		link.response     = answer & ~(badParity & strobe);
		link.checkResp    = answer & badParity & strobe;
		link.timeoutReset = active & (cnt_ff < toHold);
		link.ioIrqReq     = evIn.ioIrqReq & maskOn;
	end
endmodule

// ---- tb_ioer_handler.sv ----
// Self-checking bench for the channel controller response handler
`timescale 1ns/100ps

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected at %0t: got %0h want %0h", $time, (got), (exp)); end end

module tb_ioer_handler;
	import ioer_pkg::*;

	localparam int       NC      = 3;
	localparam int       TOC     = 20;
	localparam int       EVB [9] = '{8, 6, 9, 10, 11, 7, 7, 7, 7};
	localparam logic [3:0] EVC [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h8, 4'h4, 4'h2};

	logic                   clk_sys = 1'b0;
	logic                   rst = 1'b1;
	logic                   ioCmdValid, fetchPoint, irqEnable;
	logic [1:0]             ioCmdSel;
	ioer_link_type [NC-1:0] ctlIn, ev;
	logic [1:0]             ccv [NC];
	logic [7:0]             dly [NC], toh [NC];
	logic                   bad [NC], mute [NC];
	logic [NC-1:0]          ioStrobe_ff, permitIoIrq_ff, permitMc_ff;
	logic [NC-1:0]          maskOn;
	logic [1:0]             condCode_ff, mcCode_ff;
	logic                   busy_ff, ccValid_ff, checkErr_ff, ioAbort_ff, timeoutErr_ff;
	logic                   ioIrqDone_ff, mcIntDone_ff, mcTimedOut_ff, programIrq_ff, extIrq_ff;
	logic                   cfgAck_ff, backspaceDone_ff, ticSeen_ff, gapSeen_ff;
	ioer_ext_type           extCause_ff, cause;
	logic [11:0]            pulses;
	int                     miscompares = 0, n_checks = 0, firstAt;

	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

	assign pulses = {gapSeen_ff, ticSeen_ff, backspaceDone_ff, cfgAck_ff, extIrq_ff, programIrq_ff,
		mcIntDone_ff, ioIrqDone_ff, timeoutErr_ff, ioAbort_ff, checkErr_ff, ccValid_ff};

	ioer_handler #(.NUM_CTL(NC), .TIMEOUT_CYC(TOC)) dut (
		.clk_sys(clk_sys), .rst(rst), .ctlIn(ctlIn), .ioCmdValid(ioCmdValid),
		.ioCmdSel(ioCmdSel), .fetchPoint(fetchPoint), .irqEnable(irqEnable),
		.ioStrobe_ff(ioStrobe_ff), .permitIoIrq_ff(permitIoIrq_ff), .permitMc_ff(permitMc_ff),
		.busy_ff(busy_ff), .condCode_ff(condCode_ff), .ccValid_ff(ccValid_ff),
		.checkErr_ff(checkErr_ff), .ioAbort_ff(ioAbort_ff), .timeoutErr_ff(timeoutErr_ff),
		.ioIrqDone_ff(ioIrqDone_ff), .mcIntDone_ff(mcIntDone_ff), .mcCode_ff(mcCode_ff),
		.mcTimedOut_ff(mcTimedOut_ff), .programIrq_ff(programIrq_ff), .extIrq_ff(extIrq_ff),
		.extCause_ff(extCause_ff), .cfgAck_ff(cfgAck_ff), .backspaceDone_ff(backspaceDone_ff),
		.ticSeen_ff(ticSeen_ff), .gapSeen_ff(gapSeen_ff));

	for (genvar g = 0; g < NC; g++) begin : g_ctl
		ioer_ctl_model u_ctl (.clk_sys(clk_sys), .rst(rst), .strobe(ioStrobe_ff[g]),
			.permitIo(permitIoIrq_ff[g]), .permitMc(permitMc_ff[g]), .evIn(ev[g]), .cc(ccv[g]),
			.delay(dly[g]), .toHold(toh[g]), .badParity(bad[g]), .mute(mute[g]),
			.maskOn(maskOn[g]), .link(ctlIn[g]));
	end

	task automatic cyc();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic setCtl(input int c, input logic [1:0] v, input logic [7:0] d, input logic [7:0] t,
		input logic b, input logic m);
		ccv[c] = v;
		dly[c] = d;
		toh[c] = t;
		bad[c] = b;
		mute[c] = m;
	endtask

	// Counts one pulse bit over lim cycles; grants must match hold until it shows
	task automatic waitPulse(input int b, input int lim, input int rel, input logic [8:0] hold);
		int n;
		n = 0;
		firstAt = -1;
		cause = '1;
		for (int i = 0; i < lim; i++) begin
			cyc();
			if (i == rel) ev = '0;
			if (pulses[b] === 1'b1) begin
				n++;
				if (firstAt < 0) firstAt = i;
				cause = extCause_ff;
			end else if (n == 0 && {permitMc_ff, permitIoIrq_ff, ioStrobe_ff} !== 9'h000) begin
				`CHK({permitMc_ff, permitIoIrq_ff, ioStrobe_ff}, hold)
			end
		end
		`CHK(n, 1)
	endtask

	task automatic ioCmd(input int c, input int b, input int lim);
		ioCmdValid = 1'b1;
		ioCmdSel = 2'(c);
		cyc();
		ioCmdValid = 1'b0;
		waitPulse(b, lim, 99, 9'(1 << c));
	endtask

	function automatic ioer_link_type evOne(input int j);
		ioer_link_type e;
		e = '0;
		case (j)
			0: e.cfgAck = 1'b1;
			1: e.areaLockout = 1'b1;
			2: e.backspaceDone = 1'b1;
			3: e.transfer_in_channel = 1'b1;
			4: e.gap = 1'b1;
			5: e.directIrq = 1'b1;
			6: e.elementCheck = 1'b1;
			7: e.batteryStatus = 1'b1;
			default: e.overTemp = 1'b1;
		endcase
		return e;
	endfunction

	task automatic results();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(CLK_PERIOD_NS * 5000);
		miscompares++;
		results();
	end

	initial begin
		int c;
		logic [1:0] cc;
		void'($urandom(32'hd5e0));
		ioCmdValid = 1'b0;
		ioCmdSel = 2'h0;
		fetchPoint = 1'b0;
		irqEnable = 1'b0;
		ev = '0;
		maskOn = '1;
		for (int k = 0; k < NC; k++) setCtl(k, 2'h0, 8'h04, 8'h00, 1'b0, 1'b0);
		repeat (16) @(posedge clk_sys);
		#1 rst = 1'b0;
		`CHK({busy_ff, permitMc_ff, permitIoIrq_ff, ioStrobe_ff}, 10'h000)
		for (int k = 0; k < 12; k++) begin
			c = (k < NC) ? k : int'($urandom % NC);
			cc = 2'($urandom);
			setCtl(c, cc, 8'(2 + $urandom % 10), 8'($urandom % 15), 1'b0, 1'b0);
			ioCmd(c, 0, 20);
			`CHK({busy_ff, condCode_ff}, {1'b0, cc})
		end
		setCtl(1, 2'h2, 8'h03, 8'h00, 1'b1, 1'b0);
		ioCmd(1, 1, 10);
		setCtl(2, 2'h0, 8'h00, 8'h28, 1'b0, 1'b1);
		ioCmd(2, 3, 70);
		`CHK(firstAt >= 50, 1'b1)
		ioCmdValid = 1'b1;
		ioCmdSel = 2'h3;
		cyc();
		ioCmdValid = 1'b0;
		cyc();
		`CHK({busy_ff, ioStrobe_ff}, 4'h0)
		$display("test io finished");
		setCtl(1, 2'h0, 8'h00, 8'hff, 1'b0, 1'b1);
		ioCmdValid = 1'b1;
		ioCmdSel = 2'h1;
		cyc();
		ioCmdValid = 1'b0;
		repeat (3) cyc();
		`CHK(ioStrobe_ff, 3'h2)
		ev[1].mcReq = 1'b1;
		waitPulse(2, 6, 1, 9'h002);
		`CHK(busy_ff, 1'b0)
		$display("test abort finished");
		for (int k = 0; k < 18; k++) begin
			ev[int'($urandom % NC)] = evOne(k % 9);
			waitPulse(EVB[k % 9], 8, (k < 9) ? 0 : 4, 9'h000);
			`CHK(firstAt < 2, 1'b1)
			`CHK(cause, EVC[k % 9])
		end
		$display("test events finished");
		setCtl(2, 2'h0, 8'h05, 8'h00, 1'b0, 1'b0);
		ev[0].ioIrqReq = 1'b1;
		ev[2].ioIrqReq = 1'b1;
		repeat (3) cyc();
		`CHK(permitIoIrq_ff, 3'h0)
		maskOn = '0;
		irqEnable = 1'b1;
		repeat (3) cyc();
		`CHK({busy_ff, permitIoIrq_ff}, 4'h0)
		maskOn = '1;
		waitPulse(4, 14, 1, 9'h020);
		irqEnable = 1'b0;
		$display("test irq finished");
		setCtl(2, 2'h0, 8'h1e, 8'hff, 1'b0, 1'b0);
		setCtl(0, 2'h0, 8'h00, 8'h05, 1'b0, 1'b1);
		ev[0].mcReq = 1'b1;
		ev[2].mcReq = 1'b1;
		for (int k = 0; k < 2; k++) begin
			fetchPoint = 1'b1;
			cyc();
			fetchPoint = 1'b0;
			waitPulse(5, 40, (k == 0) ? 99 : 0, (k == 0) ? 9'h100 : 9'h040);
			`CHK(firstAt > TOC, 1'b1)
			`CHK({mcTimedOut_ff, mcCode_ff}, (k == 0) ? 3'h3 : 3'h5)
			ev[2].mcReq = 1'b0;
		end
		$display("test machine check finished");
		results();
	end
endmodule
